// ---- src/pc_trip_map.svh ----
// constants for the phase comparison trip logic
`ifndef PC_TRIP_MAP_SVH
`define PC_TRIP_MAP_SVH
`define TMR_W        16
`define SCHEME_W     2
`define SCH_ONE_BLK  2'h0
`define SCH_ONE_TRP  2'h1
`define SCH_DUAL_TRP 2'h2
`define SCH_DUAL_BLK 2'h3
`define CH_W         2
`define CH_TWO_FREQ  2'h0
`define CH_THREE_FREQ 2'h1
`define CH_ON_OFF    2'h2
`define TMR_ZERO     16'h0000
`define TMR_ONE      16'h0001
`endif

// ---- src/pc_trip_pkg.sv ----
// types for the phase comparison trip logic
package pc_trip_pkg;
  typedef struct packed {
    logic high_shift;
    logic low_shift;
  } key_t;
  typedef struct packed {
    logic [15:0] pickup;
    logic [15:0] dropout;
  } tmr_cfg_t;
endpackage : pc_trip_pkg

// ---- src/pu_do_timer.sv ----
// pickup and dropout delay timer
`timescale 1ns/100ps
`default_nettype none
`include "pc_trip_map.svh"
module pu_do_timer #(
  parameter int W = 16
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         in_level,
  input  wire logic [W-1:0] pickup,
  input  wire logic [W-1:0] dropout,
  output logic              out_level
);
  logic [W-1:0] cnt_q;
  logic         out_q;
  // ----------------------------------------
  // counts ticks while input differs from output
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else if (in_level == out_q) begin
      cnt_q <= '0;
    end else if ((in_level && cnt_q + W'(1) >= pickup) ||
                 (!in_level && cnt_q + W'(1) >= dropout)) begin
      cnt_q <= '0;
      out_q <= in_level;
    end else begin
      cnt_q <= cnt_q + W'(1);
    end
  end
  assign out_level = out_q;
endmodule : pu_do_timer
`default_nettype wire

// ---- src/pc_trip_logic.sv ----
// phase comparison trip decision logic for one terminal
// Summary of operation
// - blocking mode: receiver blocking output present inhibits trip
// - tripping mode: trip only while receiver permissive output present
// - single comparison: attempt only during positive half cycle
// - dual comparison: separate positive and negative comparer integrators
// - three-frequency: high shift positive, low negative, center unkeyed
// - interlock: never both shifts, low wins, low while low detector out
// - two-frequency dual trip: low shift, high only in positive half
// - two-frequency dual block: low shift, high in negative half
// - squarer outputs follow positive and negative half cycles only
// - detector outputs held while magnitude exceeds pickup
// - on-off dual: trip on absence one half, presence the other
// - symmetry timer delays rising or falling receiver edge
// - phase delay timer has equal pickup and dropout
// - in phase receiver blocks, opposite phase trips
// - transient gate: high detector picked up, no integrator output
// - transient timer output suppresses trip via inverted input
// - suppression lasts transient timer dropout after gate clears
// - low set detector enables high shift keying, except dual block and two-frequency dual trip
`timescale 1ns/100ps
`default_nettype none
`include "pc_trip_map.svh"
module pc_trip_logic #(
  parameter int W = `TMR_W
) (
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic [`SCHEME_W-1:0] scheme,
  input  wire logic [`CH_W-1:0]     channel,
  input  wire logic                 sym_on_fall,
  input  wire logic [W-1:0]         sym_delay,
  input  wire logic [W-1:0]         phase_delay,
  input  wire logic [W-1:0]         integ_pickup,
  input  wire pc_trip_pkg::tmr_cfg_t tb_cfg,
  input  wire logic                 sq_pos_pin,
  input  wire logic                 sq_neg_pin,
  input  wire logic                 high_set_fault_detect_pin,
  input  wire logic                 low_set_fault_detect_pin,
  input  wire logic                 rx_high_pin,
  input  wire logic                 rx_low_pin,
  output pc_trip_pkg::key_t         tx_key,
  output logic                      tx_on,
  output logic                      half_cycle_squarer_pos,
  output logic                      half_cycle_squarer_neg,
  output logic                      transient_block,
  output logic                      trip
);
  logic [1:0] rst_sync_q;
  logic       rst_n;
  logic [5:0] in_s1_q, in_s2_q, in_s3_q, in_q;
  logic [5:0] pins;
  logic       sq_pos, sq_neg, high_set_fault_detect, low_set_fault_detect, rx_hi, rx_lo;
  logic       rx_hi_c, rx_lo_c, sq_pos_d, sq_neg_d;
  logic       cmp_pos, cmp_neg, int_pos, int_neg, integ;
  logic       transient_block_gate, tb_out;
  logic       trip_q;
  pc_trip_pkg::key_t key_d, key_q;
  logic       tx_on_q;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) rst_sync_q <= 2'h0;
    else         rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------
  // pin synchronisers, change once stages 2 and 3 agree
  // ----------------------------------------
  assign pins = {sq_pos_pin, sq_neg_pin, high_set_fault_detect_pin,
                 low_set_fault_detect_pin, rx_high_pin, rx_low_pin};
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      in_s1_q <= 6'h00;
      in_s2_q <= 6'h00;
      in_s3_q <= 6'h00;
    end else begin
      in_s1_q <= pins;
      in_s2_q <= in_s1_q;
      in_s3_q <= in_s2_q;
    end
  end
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_agree
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) in_q[g] <= 1'b0;
        else if (in_s2_q[g] == in_s3_q[g]) in_q[g] <= in_s3_q[g];
      end
    end
  endgenerate
  // squarer is exclusive by half cycle; fault detectors held while high
  assign sq_pos = in_q[5] & ~in_q[4];
  assign sq_neg = in_q[4] & ~in_q[5];
  assign high_set_fault_detect    = in_q[3];
  assign low_set_fault_detect    = in_q[2];
  assign rx_hi  = in_q[1];
  assign rx_lo  = in_q[0];
  assign half_cycle_squarer_pos = sq_pos;
  assign half_cycle_squarer_neg = sq_neg;

  // ----------------------------------------
  // symmetry and phase delay timers
  // ----------------------------------------
  // delay on one edge only: other edge gets a single tick
  pu_do_timer #(.W(W)) u_sym_hi (
    .mclk(mclk), .rst_n(rst_n), .in_level(rx_hi),
    .pickup(sym_on_fall ? `TMR_ONE : sym_delay),
    .dropout(sym_on_fall ? sym_delay : `TMR_ONE),
    .out_level(rx_hi_c));
  pu_do_timer #(.W(W)) u_sym_lo (
    .mclk(mclk), .rst_n(rst_n), .in_level(rx_lo),
    .pickup(sym_on_fall ? `TMR_ONE : sym_delay),
    .dropout(sym_on_fall ? sym_delay : `TMR_ONE),
    .out_level(rx_lo_c));
  pu_do_timer #(.W(W)) u_ph_pos (
    .mclk(mclk), .rst_n(rst_n), .in_level(sq_pos),
    .pickup(phase_delay), .dropout(phase_delay),
    .out_level(sq_pos_d));
  pu_do_timer #(.W(W)) u_ph_neg (
    .mclk(mclk), .rst_n(rst_n), .in_level(sq_neg),
    .pickup(phase_delay), .dropout(phase_delay),
    .out_level(sq_neg_d));

  // ----------------------------------------
  // comparers
  // ----------------------------------------
  // remote keys in antiphase on internal faults: local positive meets
  // remote negative; in-phase reception blocks
  always_comb begin
    cmp_pos = 1'b0;
    cmp_neg = 1'b0;
    unique case (scheme)
      `SCH_ONE_BLK: begin
        cmp_pos = high_set_fault_detect & sq_pos_d & ~rx_lo_c;
      end
      `SCH_ONE_TRP: begin
        cmp_pos = high_set_fault_detect & sq_pos_d & rx_hi_c;
      end
      `SCH_DUAL_TRP: begin
        if (channel == `CH_ON_OFF) begin
          cmp_pos = high_set_fault_detect & sq_pos_d & ~rx_hi_c;
          cmp_neg = high_set_fault_detect & sq_neg_d & rx_hi_c;
        end else begin
          cmp_pos = high_set_fault_detect & sq_pos_d & rx_lo_c;
          cmp_neg = high_set_fault_detect & sq_neg_d & rx_hi_c;
        end
      end
      `SCH_DUAL_BLK: begin
        cmp_pos = high_set_fault_detect & sq_pos_d & ~rx_hi_c;
        cmp_neg = high_set_fault_detect & sq_neg_d & ~rx_lo_c;
      end
    endcase
  end

  // ----------------------------------------
  // trip integrators, one per half cycle
  // ----------------------------------------
  pu_do_timer #(.W(W)) u_int_pos (
    .mclk(mclk), .rst_n(rst_n), .in_level(cmp_pos),
    .pickup(integ_pickup), .dropout(`TMR_ONE),
    .out_level(int_pos));
  pu_do_timer #(.W(W)) u_int_neg (
    .mclk(mclk), .rst_n(rst_n), .in_level(cmp_neg),
    .pickup(integ_pickup), .dropout(`TMR_ONE),
    .out_level(int_neg));
  assign integ = int_pos | int_neg;

  // ----------------------------------------
  // transient blocking
  // ----------------------------------------
  assign transient_block_gate = high_set_fault_detect & ~integ;
  pu_do_timer #(.W(W)) u_tblk (
    .mclk(mclk), .rst_n(rst_n), .in_level(transient_block_gate),
    .pickup(tb_cfg.pickup), .dropout(tb_cfg.dropout),
    .out_level(tb_out));
  assign transient_block = tb_out;

  // final trip gate
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) trip_q <= 1'b0;
    else        trip_q <= integ & ~tb_out;
  end
  assign trip = trip_q;

  // ----------------------------------------
  // transmitter keying
  // ----------------------------------------
  always_comb begin
    key_d = '0;
    unique case (scheme)
      `SCH_DUAL_TRP: begin
        if (channel == `CH_THREE_FREQ) begin
          // low wins; low sent while low detector is out
          key_d.low_shift  = ~low_set_fault_detect | sq_neg;
          key_d.high_shift = low_set_fault_detect & sq_pos & ~key_d.low_shift;
        end else if (channel == `CH_ON_OFF) begin
          key_d.high_shift = low_set_fault_detect & sq_pos;
        end else begin
          key_d.high_shift = sq_pos;
          key_d.low_shift  = ~sq_pos;
        end
      end
      `SCH_DUAL_BLK: begin
        key_d.high_shift = sq_neg;
        key_d.low_shift  = ~sq_neg;
      end
      default: begin
        key_d.high_shift = low_set_fault_detect & sq_pos;
      end
    endcase
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      key_q   <= '0;
      tx_on_q <= 1'b0;
    end else begin
      key_q   <= key_d;
      tx_on_q <= key_d.high_shift | key_d.low_shift;
    end
  end
  assign tx_key = key_q;
  assign tx_on  = tx_on_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  trip_needs_integ_a: assert property (@(posedge mclk) disable iff (!rst_n)
    trip |-> $past(integ)) else $error("trip without integrator");
  trip_blocked_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(tb_out) |-> !trip) else $error("trip while blocked");
  shift_excl_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !(tx_key.high_shift && tx_key.low_shift))
    else $error("both shifts keyed");
  low_fdl_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (scheme == `SCH_DUAL_TRP && channel == `CH_THREE_FREQ && !low_set_fault_detect)
    |=> tx_key.low_shift) else $error("low shift missing");
  dblk_key_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (scheme == `SCH_DUAL_BLK) |=> (tx_key.high_shift == $past(sq_neg)))
    else $error("dual block key wrong");
  dtrp_key_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (scheme == `SCH_DUAL_TRP && channel == `CH_TWO_FREQ)
    |=> (tx_key.high_shift == $past(sq_pos)))
    else $error("dual trip key wrong");
  single_neg_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (scheme == `SCH_ONE_BLK || scheme == `SCH_ONE_TRP) |-> !cmp_neg)
    else $error("negative attempt in single");
  gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    transient_block_gate == (high_set_fault_detect && !integ))
    else $error("transient gate wrong");
  key_enable_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (scheme == `SCH_ONE_BLK && !low_set_fault_detect) |=> !tx_on)
    else $error("keyed without detector");
  blk_rx_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (scheme == `SCH_ONE_BLK && rx_lo_c) |-> !cmp_pos)
    else $error("attempt while blocked");
  trip_cv: cover property (@(posedge mclk) disable iff (!rst_n) $rose(trip));
  tblk_cv: cover property (@(posedge mclk) disable iff (!rst_n) $rose(tb_out));
  neg_cv: cover property (@(posedge mclk) disable iff (!rst_n) int_neg);
endmodule : pc_trip_logic
`default_nettype wire

// ---- tb/remote_term.sv ----
// remote terminal model keying the pilot channel
`timescale 1ns/100ps
`default_nettype none
`include "pc_trip_map.svh"
module remote_term (
  input  wire logic             mclk,
  input  wire logic             sq_local,
  input  wire logic             invert,
  input  wire logic [`CH_W-1:0] channel,
  input  wire logic [15:0]      lag,
  output logic                  rx_high,
  output logic                  rx_low
);
  logic [63:0] hist_q = '0;
  logic        rpos;
  always @(posedge mclk) begin
    hist_q <= {hist_q[62:0], sq_local};
  end
  // remote squared signal, lagged to match the channel delay
  assign rpos = hist_q[lag[5:0]] ^ invert;
  always_comb begin
    rx_high = rpos;
    rx_low  = (channel == `CH_ON_OFF) ? 1'b0 : ~rpos;
  end
endmodule : remote_term
`default_nettype wire

// ---- tb/pc_trip_logic_tb_top.sv ----
// self-checking bench for the phase comparison trip logic
`timescale 1ns/100ps
`default_nettype none
`include "pc_trip_map.svh"
module pc_trip_logic_tb_top;
  localparam logic [3:0] COMBO [6] = '{4'h0, 4'h4, 4'h8, 4'h9, 4'hA, 4'hC};
  logic                  mclk, resetn, sym_on_fall, high_set_fault_detect, low_set_fault_detect, pos, flip;
  logic [1:0]            scheme, channel;
  logic [15:0]           sym_delay;
  pc_trip_pkg::key_t     tx_key;
  logic                  rx_high, rx_low, tx_on, sq_p, sq_n, blk, trip;
  logic [31:0]           lfsr;
  int                    error_cnt, n_checks, ph, i;

  pc_trip_logic dut_u (.mclk(mclk), .resetn(resetn), .scheme(scheme),
    .channel(channel), .sym_on_fall(sym_on_fall), .sym_delay(sym_delay),
    .phase_delay(16'h0003), .integ_pickup(16'h0005),
    .tb_cfg({16'h0046, 16'h001E}),
    .sq_pos_pin(pos), .sq_neg_pin(~pos),
    .high_set_fault_detect_pin(high_set_fault_detect), .low_set_fault_detect_pin(low_set_fault_detect),
    .rx_high_pin(rx_high), .rx_low_pin(rx_low), .tx_key(tx_key),
    .tx_on(tx_on), .half_cycle_squarer_pos(sq_p),
    .half_cycle_squarer_neg(sq_n), .transient_block(blk), .trip(trip));
  remote_term remote_u (.mclk(mclk), .sq_local(pos), .invert(flip),
    .channel(channel), .lag(16'h0003), .rx_high(rx_high), .rx_low(rx_low));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  function automatic logic att(input logic p, input logic f);
    logic rh;
    logic rl;
    rh = p ^ f;
    rl = (channel == `CH_ON_OFF) ? 1'b0 : ~rh;
    case (scheme)
      `SCH_ONE_BLK: return p & ~rl;
      `SCH_ONE_TRP: return p & rh;
      default: return p ^ rh;
    endcase
  endfunction : att
  function automatic logic [1:0] kexp(input logic p);
    if (scheme == `SCH_DUAL_BLK) return {~p, p};
    if (scheme == `SCH_DUAL_TRP && channel == `CH_TWO_FREQ) return {p, ~p};
    if (scheme == `SCH_DUAL_TRP && channel == `CH_THREE_FREQ)
      return {low_set_fault_detect & p, ~(low_set_fault_detect & p)};
    return {low_set_fault_detect & p, 1'b0};
  endfunction : kexp
  task automatic chk(input string what, input logic [3:0] seen,
                     input logic [3:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wait_ph(input int p);
    do @(negedge mclk); while (ph != p);
  endtask : wait_ph
  task automatic probe(input logic p);
    logic [1:0] k;
    logic       any;
    k = kexp(p);
    any = att(1'b1, flip) | (scheme[1] & att(1'b0, flip));
    chk("squarer", {2'b00, sq_p, sq_n}, {2'b00, p, ~p});
    chk("key", {1'b0, tx_on, tx_key}, {1'b0, |k, k});
    chk("trip", {3'b000, trip}, {3'b000, high_set_fault_detect & att(p, flip)});
    chk("block", {3'b000, blk}, {3'b000, high_set_fault_detect & ~any});
  endtask : probe
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // clock, phase and watchdog
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    ph <= (ph + 1) % 80;
    pos <= ((ph + 1) % 80) < 40;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {resetn, high_set_fault_detect, low_set_fault_detect, flip, sym_on_fall, scheme, channel} = '0;
    {error_cnt, n_checks, ph} = '0;
    pos = 1'b1;
    sym_delay = 16'h0002;
    lfsr = 32'h5DF8AFD4;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    for (i = 0; i < 18; i++) begin
      @(posedge mclk);
      high_set_fault_detect <= 1'b0;
      repeat (120) @(posedge mclk);
      lfsr = nxt(lfsr);
      {scheme, channel} <= COMBO[i % 6];
      {high_set_fault_detect, low_set_fault_detect, flip, sym_on_fall} <= lfsr[3:0];
      sym_delay <= {14'h0000, lfsr[5:4]} + 16'h0001;
      repeat (320) @(posedge mclk);
      wait_ph(30);
      probe(1'b1);
      wait_ph(70);
      probe(1'b0);
      $display("test %0d done", i);
    end
    // external fault held, then internal fault while still suppressed
    @(posedge mclk);
    {scheme, channel} <= 4'h0;
    {high_set_fault_detect, flip} <= 2'b11;
    repeat (300) @(posedge mclk);
    wait_ph(79);
    @(posedge mclk);
    flip <= 1'b0;
    wait_ph(30);
    chk("held", {2'b00, trip, blk}, 4'h1);
    wait_ph(30);
    chk("release", {2'b00, trip, blk}, 4'h2);
    flip <= 1'b1;
    repeat (300) @(posedge mclk);
    high_set_fault_detect <= 1'b0;
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    chk("dropout", {3'b000, blk}, 4'h1);
    repeat (40) @(posedge mclk);
    @(negedge mclk);
    chk("cleared", {3'b000, blk}, 4'h0);
    $display("transient test done");
    tally_and_finish();
  end
endmodule : pc_trip_logic_tb_top
`default_nettype wire
